// file: mac_ctrl_defs.sv
// Constants, carrier types and helpers for the MAC control register bank.
package mac_ctrl_defs;
	localparam int           CLK_PERIOD_NS    = 5;
	localparam int           PROM_HALF_NS     = 1000;
	localparam int           PROM_HALF_CYC    =
		(PROM_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]   PROM_HALF_LAST   = 8'(PROM_HALF_CYC - 1);
	localparam int           PROM_FRAME_BITS  = 25;
	localparam logic [4:0]   PROM_FRAME_COUNT = 5'(PROM_FRAME_BITS);
	localparam logic [2:0]   PROM_READ_CMD    = 3'h6;
	localparam logic [5:0]   PROM_WORD_LOW    = 6'h01;
	localparam logic [5:0]   PROM_WORD_MIDDLE = 6'h02;
	localparam logic [5:0]   PROM_WORD_HIGH   = 6'h03;
	localparam logic [5:0]   PROM_WORD_CFG    = 6'h06;
	localparam logic [1:0]   PROM_LAST_WORD   = 2'h3;
	localparam logic [11:0]  IDX_STATION_LOW  = 12'h200;
	localparam logic [11:0]  IDX_STATION_MID  = 12'h202;
	localparam logic [11:0]  IDX_STATION_HIGH = 12'h204;
	localparam logic [11:0]  IDX_BUS_SPEED    = 12'h210;
	localparam logic [11:0]  IDX_PROM_CTRL    = 12'h212;
	localparam logic [11:0]  IDX_SELFTEST     = 12'h214;
	localparam logic [11:0]  IDX_SOFT_RESET   = 12'h216;
	localparam logic [11:0]  IDX_POWER_CAPS   = 12'h218;
	localparam logic [11:0]  IDX_WAKE_CTRL    = 12'h21a;
	localparam logic [11:0]  ADDR_STATION_LOW  = IDX_STATION_LOW << 2;
	localparam logic [11:0]  ADDR_STATION_MID  = IDX_STATION_MID << 2;
	localparam logic [11:0]  ADDR_STATION_HIGH = IDX_STATION_HIGH << 2;
	localparam logic [11:0]  ADDR_BUS_SPEED    = IDX_BUS_SPEED << 2;
	localparam logic [11:0]  ADDR_PROM_CTRL    = IDX_PROM_CTRL << 2;
	localparam logic [11:0]  ADDR_SELFTEST     = IDX_SELFTEST << 2;
	localparam logic [11:0]  ADDR_SOFT_RESET   = IDX_SOFT_RESET << 2;
	localparam logic [11:0]  ADDR_POWER_CAPS   = IDX_POWER_CAPS << 2;
	localparam logic [11:0]  ADDR_WAKE_CTRL    = IDX_WAKE_CTRL << 2;
	localparam logic [1:0]   BUS_SPEED_125     = 2'h0;
	localparam logic [1:0]   BUS_SPEED_62_5    = 2'h1;
	localparam logic [1:0]   BUS_SPEED_41_66   = 2'h2;
	localparam logic [1:0]   BUS_SPEED_25      = 2'h3;
	localparam logic [1:0]   BUS_SPEED_RESET   = BUS_SPEED_25;
	localparam int           PROM_SW_EN_BIT    = 4;
	localparam int           PROM_DI_BIT       = 3;
	localparam int           PROM_DO_BIT       = 2;
	localparam int           PROM_SK_BIT       = 1;
	localparam int           PROM_CS_BIT       = 0;
	localparam int           TX_DONE_BIT       = 12;
	localparam int           TX_FAIL_BIT       = 11;
	localparam int           RX_DONE_BIT       = 4;
	localparam int           RX_FAIL_BIT       = 3;
	localparam int           SOFT_RESET_BIT    = 0;
	localparam logic [7:0]   WAKE_CTL_MASK     = 8'h8f;
	localparam logic [15:0]  PM_CAPS_RESET     = 16'h4000;
	localparam logic [15:0]  PM_CFG_MASK       = 16'h362f;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} apb_rsp_t;

	typedef struct packed {
		logic chip_select;
		logic serial_clock;
		logic serial_output;
	} prom_pins_t;

	typedef enum logic [2:0] {
		ST_WAIT  = 3'h0,
		ST_SEL   = 3'h1,
		ST_SHIFT = 3'h3,
		ST_GAP   = 3'h2,
		ST_DONE  = 3'h6
	} loader_state_t;

	typedef enum logic [1:0] {
		PWR_D0     = 2'h0,
		PWR_D1     = 2'h1,
		PWR_D2     = 2'h2,
		PWR_D3_HOT = 2'h3
	} power_state_t;

	// Fixed bits 15, 14, 11 and the zero auxiliary current field are forced.
	function automatic logic [15:0] power_caps_word(input logic [15:0] cfg);
		return (cfg & PM_CFG_MASK) | PM_CAPS_RESET;
	endfunction
endpackage

// file: mac_ctrl_regs.sv
// Control and status register bank with serial PROM loader and APB slave.
`timescale 1ns/10ps
module mac_ctrl_regs
	import mac_ctrl_defs::*;
(
	// Clock and reset.
	input  logic         mclk,
	input  logic         reset,
	// APB slave.
	input  apb_req_t     apb_req,
	output apb_rsp_t     apb_rsp,
	// Serial configuration PROM.
	input  logic         prom_present_strap,
	input  logic         prom_serial_input_pin,
	output prom_pins_t   prom_pins,
	// Memory self-test results.
	input  logic         tx_selftest_done,
	input  logic         tx_selftest_failed,
	input  logic         rx_selftest_done,
	input  logic         rx_selftest_failed,
	// Power management.
	input  power_state_t power_state,
	input  logic         wake_enable,
	input  logic         wake_detected,
	output logic         wake_event_pin,
	output logic [15:0]  pci_capability_word,
	// Control outputs to the rest of the device.
	output logic [47:0]  station_address,
	output logic [1:0]   bus_speed_select,
	output logic         network_wake_packet_enable,
	output logic [3:0]   wake_pattern_enable,
	output logic         soft_reset_active,
	output logic         loader_done
);

	typedef struct packed {
		loader_state_t fsm;
		logic          strap;
		logic [7:0]    div;
		logic [4:0]    bits;
		logic [1:0]    word;
		logic [24:0]   shift;
		prom_pins_t    hw_pins;
		prom_pins_t    pins;
		logic [15:0]   addr_low;
		logic [15:0]   addr_mid;
		logic [15:0]   addr_high;
		logic [1:0]    bus_speed;
		logic [3:0]    prom_ctl;
		logic [3:0]    selftest;
		logic          soft_rst;
		logic [15:0]   pm_caps;
		logic [7:0]    wake_ctl;
		logic          wake_pin;
		logic          load_done;
		apb_rsp_t      rsp;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next;
	logic        apb_access;
	logic        apb_write;
	logic        tick;
	logic [15:0] prom_word;
	logic        in_d1;
	logic        in_d2;
	logic        in_d3;

	function automatic logic [5:0] prom_word_addr(input logic [1:0] idx);
		case (idx)
		2'h0: return PROM_WORD_LOW;
		2'h1: return PROM_WORD_MIDDLE;
		2'h2: return PROM_WORD_HIGH;
		default: return PROM_WORD_CFG;
		endcase
	endfunction

	function automatic logic is_mapped(input logic [11:0] a);
		case (a)
		ADDR_STATION_LOW, ADDR_STATION_MID, ADDR_STATION_HIGH,
		ADDR_BUS_SPEED, ADDR_PROM_CTRL, ADDR_SELFTEST,
		ADDR_SOFT_RESET, ADDR_POWER_CAPS, ADDR_WAKE_CTRL: return 1'b1;
		default: return 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] read_word(input logic [11:0] a,
		input ctrl_state_t st, input logic di);
		logic [15:0] v;
		v = 16'h0000;
		case (a)
		ADDR_STATION_LOW:  v = st.addr_low;
		ADDR_STATION_MID:  v = st.addr_mid;
		ADDR_STATION_HIGH: v = st.addr_high;
		ADDR_BUS_SPEED:    v[1:0] = st.bus_speed;
		ADDR_PROM_CTRL: begin
			v[PROM_SW_EN_BIT] = st.prom_ctl[3];
			v[PROM_DI_BIT]    = di;
			v[PROM_DO_BIT]    = st.prom_ctl[2];
			v[PROM_SK_BIT]    = st.prom_ctl[1];
			v[PROM_CS_BIT]    = st.prom_ctl[0];
		end
		ADDR_SELFTEST: begin
			v[TX_DONE_BIT] = st.selftest[3];
			v[TX_FAIL_BIT] = st.selftest[2];
			v[RX_DONE_BIT] = st.selftest[1];
			v[RX_FAIL_BIT] = st.selftest[0];
		end
		ADDR_SOFT_RESET:   v[SOFT_RESET_BIT] = st.soft_rst;
		ADDR_POWER_CAPS:   v = st.pm_caps;
		ADDR_WAKE_CTRL:    v[7:0] = st.wake_ctl;
		default:           v = 16'h0000;
		endcase
		return {16'h0000, v};
	endfunction

	assign apb_access = apb_req.psel && apb_req.penable;
	assign apb_write  = apb_access && s.rsp.pready && apb_req.pwrite;
	assign tick       = (s.div == PROM_HALF_LAST);
	assign prom_word  = {s.shift[14:0], prom_serial_input_pin};
	assign in_d1      = (power_state == PWR_D1);
	assign in_d2      = (power_state == PWR_D2);
	assign in_d3      = (power_state == PWR_D3_HOT);

	always_comb begin
		next = s;
		next.rsp.pready  = 1'b0;
		next.rsp.pslverr = 1'b0;
		next.selftest = {tx_selftest_done, tx_selftest_failed,
			rx_selftest_done, rx_selftest_failed};

		// Serial PROM loader: half-period divider and frame sequencer.
		if (s.fsm == ST_WAIT || s.fsm == ST_DONE || tick) begin
			next.div = 8'h00;
		end else begin
			next.div = s.div + 8'h01;
		end
		case (s.fsm)
		ST_WAIT: begin
			next.strap = prom_present_strap;
			if (prom_present_strap) begin
				next.fsm = ST_SEL;
			end else begin
				next.fsm       = ST_DONE;
				next.load_done = 1'b1;
			end
		end
		ST_SEL: begin
			if (tick) begin
				next.shift = {PROM_READ_CMD, prom_word_addr(s.word), 16'h0000};
				next.hw_pins.chip_select   = 1'b1;
				next.hw_pins.serial_clock  = 1'b0;
				next.hw_pins.serial_output = PROM_READ_CMD[2];
				next.bits = 5'h00;
				next.fsm  = ST_SHIFT;
			end
		end
		ST_SHIFT: begin
			if (tick && !s.hw_pins.serial_clock) begin
				next.hw_pins.serial_clock = 1'b1;
				next.bits = s.bits + 5'h01;
			end else if (tick) begin
				next.hw_pins.serial_clock  = 1'b0;
				next.shift = {s.shift[23:0], prom_serial_input_pin};
				next.hw_pins.serial_output = s.shift[23];
				if (s.bits == PROM_FRAME_COUNT) begin
					next.hw_pins.chip_select   = 1'b0;
					next.hw_pins.serial_output = 1'b0;
					next.fsm = ST_GAP;
					case (s.word)
					2'h0: next.addr_low  = prom_word;
					2'h1: next.addr_mid  = prom_word;
					2'h2: next.addr_high = prom_word;
					default: next.pm_caps = power_caps_word(prom_word);
					endcase
				end
			end
		end
		ST_GAP: begin
			if (tick) begin
				next.word = s.word + 2'h1;
				if (s.word == PROM_LAST_WORD) begin
					next.fsm       = ST_DONE;
					next.load_done = 1'b1;
				end else begin
					next.fsm = ST_SEL;
				end
			end
		end
		ST_DONE: next.fsm = ST_DONE;
		default: next.fsm = ST_WAIT;
		endcase

		// APB slave: one wait state, then the write lands and read data stands.
		if (apb_access && !s.rsp.pready) begin
			next.rsp.pready  = 1'b1;
			next.rsp.prdata  = read_word(apb_req.paddr, s, prom_serial_input_pin);
			next.rsp.pslverr = !is_mapped(apb_req.paddr);
		end
		if (apb_write) begin
			case (apb_req.paddr)
			ADDR_STATION_LOW:  next.addr_low  = apb_req.pwdata[15:0];
			ADDR_STATION_MID:  next.addr_mid  = apb_req.pwdata[15:0];
			ADDR_STATION_HIGH: next.addr_high = apb_req.pwdata[15:0];
			ADDR_BUS_SPEED:    next.bus_speed = apb_req.pwdata[1:0];
			ADDR_PROM_CTRL: begin
				next.prom_ctl = {apb_req.pwdata[PROM_SW_EN_BIT],
					apb_req.pwdata[PROM_DO_BIT], apb_req.pwdata[PROM_SK_BIT],
					apb_req.pwdata[PROM_CS_BIT]};
			end
			ADDR_SOFT_RESET:   next.soft_rst = apb_req.pwdata[SOFT_RESET_BIT];
			ADDR_WAKE_CTRL:    next.wake_ctl = apb_req.pwdata[7:0] & WAKE_CTL_MASK;
			default:           next.soft_rst = s.soft_rst;
			endcase
		end

		// Soft reset holds bus speed, PROM control and wake control at their defaults; station address is not held.
		if (s.soft_rst) begin
			next.bus_speed = BUS_SPEED_RESET;
			next.prom_ctl  = 4'h0;
			next.wake_ctl  = 8'h00;
		end

		// Pin owner: software bits when enabled, otherwise the loader.
		if (s.prom_ctl[3]) begin
			next.pins.chip_select   = s.prom_ctl[0];
			next.pins.serial_clock  = s.prom_ctl[1];
			next.pins.serial_output = s.prom_ctl[2];
		end else begin
			next.pins = s.hw_pins;
		end

		// Wake pin per power state; never asserted in D0.
		next.wake_pin = wake_enable && wake_detected && ((in_d3 && s.pm_caps[14])
			|| (in_d2 && s.pm_caps[13]) || (in_d1 && s.pm_caps[12]));
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s           <= '0;
			s.fsm       <= ST_WAIT;
			s.bus_speed <= BUS_SPEED_RESET;
			s.pm_caps   <= PM_CAPS_RESET;
		end else begin
			s <= next;
		end
	end

	assign apb_rsp                    = s.rsp;
	assign prom_pins                  = s.pins;
	assign wake_event_pin             = s.wake_pin;
	assign pci_capability_word        = s.pm_caps;
	assign station_address            = {s.addr_high, s.addr_mid, s.addr_low};
	assign bus_speed_select           = s.bus_speed;
	assign network_wake_packet_enable = s.wake_ctl[7];
	assign wake_pattern_enable        = s.wake_ctl[3:0];
	assign soft_reset_active          = s.soft_rst;
	assign loader_done                = s.load_done;

	// Checks on the register bank and the PROM loader.
	logic [1:0]  wr_data_speed;
	logic [7:0]  wr_data_wake;
	logic        rd_prom;
	logic        rd_selftest;
	logic        rd_caps;
	logic        wake_frame_zero;
	assign wake_frame_zero = (wake_pattern_enable == 4'h0);
	assign wr_data_speed = apb_req.pwdata[1:0];
	assign wr_data_wake  = apb_req.pwdata[7:0];
	assign rd_prom     = apb_access && !s.rsp.pready
		&& apb_req.paddr == ADDR_PROM_CTRL;
	assign rd_selftest = apb_access && !s.rsp.pready
		&& apb_req.paddr == ADDR_SELFTEST;
	assign rd_caps     = apb_access && !s.rsp.pready
		&& apb_req.paddr == ADDR_POWER_CAPS;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	frame_length_a: assert property (
		$fell(s.hw_pins.chip_select) |-> s.bits == PROM_FRAME_COUNT)
		else $error("PROM frame ended after a wrong number of clocks.");
	speed_write_a: assert property (
		apb_write && apb_req.paddr == ADDR_BUS_SPEED && !s.soft_rst
		|=> bus_speed_select == $past(wr_data_speed))
		else $error("Bus speed write did not take effect.");
	soft_reset_a: assert property (
		apb_write && apb_req.paddr == ADDR_SOFT_RESET && apb_req.pwdata[0]
		|=> soft_reset_active ##1 (bus_speed_select == BUS_SPEED_RESET
		&& wake_frame_zero && !network_wake_packet_enable))
		else $error("Soft reset did not restore control defaults.");
	prom_sw_pins_a: assert property (
		s.prom_ctl[3] |=> prom_pins.chip_select == $past(s.prom_ctl[0])
		&& prom_pins.serial_clock == $past(s.prom_ctl[1])
		&& prom_pins.serial_output == $past(s.prom_ctl[2]))
		else $error("PROM pins do not follow the software bits.");
	prom_hw_pins_a: assert property (
		!s.prom_ctl[3] |=> prom_pins == $past(s.hw_pins))
		else $error("PROM pins not owned by the loader.");
	prom_input_read_a: assert property (
		rd_prom |=> apb_rsp.pready
		&& apb_rsp.prdata[PROM_DI_BIT] == $past(prom_serial_input_pin))
		else $error("PROM input bit does not show the pin.");
	tx_selftest_a: assert property (
		rd_selftest |=> apb_rsp.prdata[TX_DONE_BIT] == $past(tx_selftest_done, 2)
		&& apb_rsp.prdata[TX_FAIL_BIT] == $past(tx_selftest_failed, 2))
		else $error("Transmit self-test flags read wrong.");
	rx_selftest_a: assert property (
		rd_selftest |=> apb_rsp.prdata[RX_DONE_BIT] == $past(rx_selftest_done, 2)
		&& apb_rsp.prdata[RX_FAIL_BIT] == $past(rx_selftest_failed, 2))
		else $error("Receive self-test flags read wrong.");
	caps_mirror_a: assert property (
		rd_caps |=> apb_rsp.prdata[15:0] == $past(pci_capability_word))
		else $error("Capability read differs from the PCI mirror.");
	caps_fixed_a: assert property (
		pci_capability_word[15:14] == 2'h1 && !pci_capability_word[11]
		&& pci_capability_word[8:6] == 3'h0)
		else $error("Fixed capability bits are wrong.");
	no_prom_caps_a: assert property (
		s.fsm == ST_DONE && !s.strap |-> pci_capability_word[10:9] == 2'h0)
		else $error("State support reported without a PROM.");
	wake_d0_a: assert property (
		power_state == PWR_D0 || !wake_enable |=> !wake_event_pin)
		else $error("Wake pin driven while not allowed.");
	wake_d2_a: assert property (
		wake_enable && wake_detected && in_d2
		|=> wake_event_pin == $past(s.pm_caps[13]))
		else $error("Wake pin in D2 does not follow its capability bit.");
	wake_d1_a: assert property (
		wake_enable && wake_detected && in_d1
		|=> wake_event_pin == $past(s.pm_caps[12]))
		else $error("Wake pin in D1 does not follow its capability bit.");
	caps_load_a: assert property (
		$changed(pci_capability_word) |-> s.strap && s.fsm == ST_GAP)
		else $error("Capability word changed outside a PROM load.");
	wake_ctrl_write_a: assert property (
		apb_write && apb_req.paddr == ADDR_WAKE_CTRL && !s.soft_rst
		|=> wake_pattern_enable == $past(wr_data_wake[3:0])
		&& network_wake_packet_enable == $past(wr_data_wake[7]))
		else $error("Wake control write did not take effect.");
endmodule // mac_ctrl_regs

// file: prom_model.sv
// Behavioural serial configuration PROM that answers read commands.
`timescale 1ns/10ps
module prom_model #(
	parameter logic [15:0] WORD_LOW  = 16'h89ab,
	parameter logic [15:0] WORD_MID  = 16'h4567,
	parameter logic [15:0] WORD_HIGH = 16'h0123,
	parameter logic [15:0] WORD_CFG  = 16'hffff
) (
	// Pins as seen from the PROM.
	input  logic chip_select,
	input  logic serial_clock,
	input  logic serial_input,
	output logic serial_output,
	// Number of commands that were not reads.
	output int   other_cmds
);
	logic [15:0] mem [0:63];
	logic [8:0]  cmd;
	logic [15:0] word;
	int          pulses;

	initial begin
		foreach (mem[i]) mem[i] = 16'h0;
		mem[1] = WORD_LOW;
		mem[2] = WORD_MID;
		mem[3] = WORD_HIGH;
		mem[6] = WORD_CFG;
		other_cmds = 0;
		pulses = 0;
		serial_output = 1'b0;
	end

	// A released data line shows the inverse of its last value.
	always @(negedge chip_select) begin
		pulses = 0;
		serial_output = ~serial_output;
	end

	// Command bits come in on rising clocks, data goes out msb first.
	always @(posedge serial_clock) begin
		if (chip_select) begin
			pulses = pulses + 1;
			if (pulses <= 9)
				cmd = {cmd[7:0], serial_input};
			if (pulses == 9) begin
				word = mem[cmd[5:0]];
				if (cmd[8:6] != 3'h6)
					other_cmds = other_cmds + 1;
			end
			if (pulses >= 10 && pulses <= 25) begin
				serial_output = word[15];
				word = {word[14:0], 1'b0};
			end
		end
	end
endmodule // prom_model

// file: mac_ctrl_regs_test.sv
// Self-checking testbench for the MAC control register bank.
`timescale 1ns/10ps
module mac_ctrl_regs_test;
	import mac_ctrl_defs::*;
	logic         mclk;
	logic         reset;
	apb_req_t     req;
	apb_rsp_t     rsp;
	logic         strap;
	logic         di_force;
	logic         di_level;
	logic         model_do;
	prom_pins_t   pins;
	logic [3:0]   bist;
	power_state_t pstate;
	logic         wake_en;
	logic         wake_det;
	logic         wake_pin;
	logic [15:0]  pci_word;
	logic [47:0]  station;
	logic [1:0]   speed;
	logic         pkt_en;
	logic [3:0]   pat_en;
	logic         srst;
	logic         ldone;
	int           other_cmds;
	int           errors;
	int           compares;
	logic [31:0]  rd;
	logic         err;

	mac_ctrl_regs dut (
		.mclk                       (mclk),
		.reset                      (reset),
		.apb_req                    (req),
		.apb_rsp                    (rsp),
		.prom_present_strap         (strap),
		.prom_serial_input_pin      (di_force ? di_level : model_do),
		.prom_pins                  (pins),
		.tx_selftest_done           (bist[3]),
		.tx_selftest_failed         (bist[2]),
		.rx_selftest_done           (bist[1]),
		.rx_selftest_failed         (bist[0]),
		.power_state                (pstate),
		.wake_enable                (wake_en),
		.wake_detected              (wake_det),
		.wake_event_pin             (wake_pin),
		.pci_capability_word        (pci_word),
		.station_address            (station),
		.bus_speed_select           (speed),
		.network_wake_packet_enable (pkt_en),
		.wake_pattern_enable        (pat_en),
		.soft_reset_active          (srst),
		.loader_done                (ldone)
	);

	prom_model prom (
		.chip_select   (pins.chip_select),
		.serial_clock  (pins.serial_clock),
		.serial_input  (pins.serial_output),
		.serial_output (model_do),
		.other_cmds    (other_cmds)
	);

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	task automatic end_sim;
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic cmp(input logic [47:0] got, input logic [47:0] exp,
		input string what);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time,
				what, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd);
		@(posedge mclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge mclk);
		req.penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (rsp.pready !== 1'b1);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
		input string what);
		apb(1'b0, a, 32'h0);
		cmp({err, rd}, {1'b0, exp}, what);
	endtask

	task automatic wait_load(input int limit);
		int n;
		n = 0;
		while (ldone !== 1'b1 && n < limit) begin
			@(posedge mclk);
			n++;
		end
		if (n >= limit) begin
			errors++;
			$display("wrong value at %0t: load never ended", $time);
		end
		tick(1);
	endtask

	initial begin
		#400000;
		errors++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_sim;
	end

	initial begin
		req = '0;
		reset = 1'b1;
		strap = 1'b1;
		di_force = 1'b0;
		di_level = 1'b0;
		bist = 4'h0;
		pstate = PWR_D0;
		wake_en = 1'b0;
		wake_det = 1'b0;
		errors = 0;
		compares = 0;
		tick(12);
		cmp(speed, BUS_SPEED_RESET, "reset speed");
		@(posedge mclk);
		reset <= 1'b0;
		rd_chk(ADDR_BUS_SPEED, 32'h3, "speed after reset");
		wait_load(50000);
		cmp(station, 48'h0123_4567_89ab, "station");
		rd_chk(ADDR_STATION_LOW, 32'h89ab, "low");
		rd_chk(ADDR_STATION_MID, 32'h4567, "mid");
		rd_chk(ADDR_STATION_HIGH, 32'h0123, "high");
		cmp(pci_word, 16'h762f, "pci mirror");
		wr(ADDR_POWER_CAPS, 32'h0);
		rd_chk(ADDR_POWER_CAPS, 32'h762f, "caps");
		wr(ADDR_STATION_LOW, 32'h1122);
		wr(ADDR_STATION_MID, 32'h3344);
		wr(ADDR_STATION_HIGH, 32'h5566);
		tick(1);
		cmp(station, 48'h5566_3344_1122, "station write");
		rd_chk(ADDR_STATION_MID, 32'h3344, "mid write");
		cmp(other_cmds, 0, "prom untouched");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_BUS_SPEED, 32'hfffc | 32'(i));
			tick(1);
			cmp(speed, i[1:0], "speed");
			rd_chk(ADDR_BUS_SPEED, 32'(i), "speed read");
		end
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_PROM_CTRL, 32'h10 | 32'(i));
			di_force <= 1'b1;
			di_level <= i[3];
			tick(3);
			cmp(pins, {i[0], i[1], i[2]}, "prom pins");
			rd_chk(ADDR_PROM_CTRL, 32'h10 | 32'(i), "prom ctl");
		end
		wr(ADDR_PROM_CTRL, 32'h7);
		tick(2);
		cmp(pins, 3'h0, "pins released");
		for (int i = 0; i < 16; i++) begin
			@(posedge mclk);
			bist <= i[3:0];
			tick(2);
			rd_chk(ADDR_SELFTEST, 32'({i[3:2], 6'h0, i[1:0], 3'h0}),
				"selftest");
		end
		wr(ADDR_WAKE_CTRL, 32'hffff);
		tick(1);
		cmp({pkt_en, pat_en}, 5'h1f, "wake outputs");
		rd_chk(ADDR_WAKE_CTRL, 32'h8f, "wake ctl");
		wr(ADDR_WAKE_CTRL, 32'h5);
		tick(1);
		cmp({pkt_en, pat_en}, 5'h05, "wake pattern");
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk);
			wake_det <= 1'b1;
			pstate <= power_state_t'(i[1:0]);
			wake_en <= i[2];
			tick(3);
			cmp(wake_pin, i[2] && i[1:0] != 2'h0, "wake pin");
		end
		wr(ADDR_BUS_SPEED, 32'h0);
		wr(ADDR_SOFT_RESET, 32'h1);
		tick(2);
		cmp({srst, speed, pkt_en, pat_en}, 8'he0, "soft reset");
		rd_chk(ADDR_SOFT_RESET, 32'h1, "soft reset read");
		wr(ADDR_BUS_SPEED, 32'h1);
		tick(1);
		cmp(speed, 2'h3, "held in soft reset");
		wr(ADDR_SOFT_RESET, 32'h0);
		wr(ADDR_BUS_SPEED, 32'h1);
		tick(1);
		cmp({srst, speed}, 3'h1, "soft reset released");
		apb(1'b1, 12'h900, 32'hffff);
		cmp(err, 1'b1, "unmapped write");
		apb(1'b0, 12'h900, 32'h0);
		cmp({err, rd}, {1'b1, 32'h0}, "unmapped read");
		@(posedge mclk);
		reset <= 1'b1;
		strap <= 1'b0;
		repeat (12) @(posedge mclk);
		reset <= 1'b0;
		wait_load(2000);
		cmp(pci_word, 16'h4000, "caps without prom");
		rd_chk(ADDR_POWER_CAPS, 32'h4000, "caps read");
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			pstate <= power_state_t'(i[1:0]);
			wake_en <= 1'b1;
			tick(3);
			cmp(wake_pin, i == 3, "wake pin without prom");
		end
		end_sim;
	end
endmodule // mac_ctrl_regs_test
